/* hdl/cam_map.vh */
// Register map, field positions and codes for the counter array mode block
`ifndef CAM_MAP_VH
`define CAM_MAP_VH

`define CAM_NUM_MODULES 6
`define CAM_WDT_MODULE 5
`define CAM_SYNC_DEPTH 3

// Mode registers and the cycle configuration register
`define CAM_ADDR_MODE0 8'hda
`define CAM_ADDR_MODE1 8'hdb
`define CAM_ADDR_MODE2 8'hdc
`define CAM_ADDR_MODE3 8'hdd
`define CAM_ADDR_MODE4 8'hde
`define CAM_ADDR_MODE5 8'hce
`define CAM_ADDR_PWM_CFG 8'hdf

// Compare low and high byte addresses
`define CAM_ADDR_LO0 8'hfb
`define CAM_ADDR_LO1 8'he9
`define CAM_ADDR_LO2 8'heb
`define CAM_ADDR_LO3 8'hed
`define CAM_ADDR_LO4 8'hfd
`define CAM_ADDR_LO5 8'hd2
`define CAM_ADDR_HI0 8'hfc
`define CAM_ADDR_HI1 8'hea
`define CAM_ADDR_HI2 8'hec
`define CAM_ADDR_HI3 8'hee
`define CAM_ADDR_HI4 8'hfe
`define CAM_ADDR_HI5 8'hd3

// Mode register fields
`define CAM_MODE_WIDE_PWM 7
`define CAM_MODE_CMP_EN 6
`define CAM_MODE_RISE_CAP 5
`define CAM_MODE_FALL_CAP 4
`define CAM_MODE_MATCH 3
`define CAM_MODE_TOGGLE 2
`define CAM_MODE_PWM 1
`define CAM_MODE_FLAG_IRQ 0
`define CAM_MODE_RESET 8'h00

// Cycle configuration fields
`define CAM_CFG_RELOAD_SEL 7
`define CAM_CFG_COV_IRQ 6
`define CAM_CFG_COV_FLAG 5
`define CAM_CFG_LEN_HI 1
`define CAM_CFG_LEN_LO 0
`define CAM_CFG_RESET 8'h00
`define CAM_UNUSED_READ 3'h0

// Cycle length codes, the counter masks they select, and the 16-bit and frequency masks
`define CAM_LEN_8 2'h0
`define CAM_LEN_9 2'h1
`define CAM_LEN_10 2'h2
`define CAM_LEN_11 2'h3
`define CAM_MASK_8 16'h00ff
`define CAM_MASK_9 16'h01ff
`define CAM_MASK_10 16'h03ff
`define CAM_MASK_11 16'h07ff
`define CAM_MASK_16 16'hffff
`define CAM_MASK_FREQ 16'h00ff

`define CAM_NO_MODULE 3'h7
`define CAM_BYTE_ZERO 8'h00
`define CAM_WORD_ZERO 16'h0000

`endif

/* hdl/cam_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module cam_sync (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Pin and filtered level
    input wire pin_in,
    output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;

// First stage feeds only the second; level moves once stages two and three agree
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
    end else begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
end

endmodule
`default_nettype wire

/* hdl/cam_channel.v */
// One capture/compare module: compare register, capture, match, toggle, PWM
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.vh"
module cam_channel (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Configuration
    input wire [7:0] mode,
    input wire [15:0] len_mask,
    input wire [15:0] reload,
    input wire reload_allowed,
    // Counter
    input wire [15:0] count_value,
    input wire count_tick,
    input wire cycle_ovf,
    // Software writes to the compare register
    input wire wr_lo,
    input wire wr_hi,
    input wire [7:0] wdata,
    // Synchronised pin edges
    input wire pin_rise,
    input wire pin_fall,
    // Results
    output reg [15:0] compare_q,
    output wire match_hit,
    output wire event_set,
    output reg pin_q
);

wire pwm_en = mode[`CAM_MODE_PWM];
wire tog_en = mode[`CAM_MODE_TOGGLE];
wire wide = mode[`CAM_MODE_WIDE_PWM];
wire freq_mode = tog_en & pwm_en; // see [R14]
// 16-bit PWM ignores the shared length field
wire [15:0] pwm_mask = wide ? `CAM_MASK_16 : len_mask; // see [R8] [R9]
wire [15:0] mask = freq_mode ? `CAM_MASK_FREQ : (pwm_en ? pwm_mask : `CAM_MASK_16);
wire [15:0] cnt_m = count_value & mask;
wire [15:0] cmp_m = compare_q & mask;
wire capture = (pin_rise & mode[`CAM_MODE_RISE_CAP]) |
               (pin_fall & mode[`CAM_MODE_FALL_CAP]); // see [R11]

assign match_hit = count_tick & mode[`CAM_MODE_CMP_EN] & (cnt_m == cmp_m); // see [R10]
assign event_set = capture | (match_hit & mode[`CAM_MODE_MATCH]); // see [R12]

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        compare_q <= `CAM_WORD_ZERO;
    end else if (wr_lo) begin
        compare_q[7:0] <= wdata;
    end else if (wr_hi) begin
        compare_q[15:8] <= wdata;
    end else if (capture) begin
        compare_q <= count_value;
    end else if (cycle_ovf & pwm_en & ~wide & ~tog_en & reload_allowed) begin
        // Duty updates land on a cycle boundary
        compare_q <= reload; // see [R22] [R2]
    end else if (freq_mode & match_hit) begin
        compare_q[7:0] <= compare_q[7:0] + compare_q[15:8];
    end
end

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        pin_q <= 1'b0;
    end else if (tog_en) begin
        if (match_hit) begin
            pin_q <= ~pin_q; // see [R13]
        end
    end else if (pwm_en) begin
        pin_q <= (cnt_m >= cmp_m); // see [R15]
    end
end

endmodule
`default_nettype wire

/* hdl/cam_top.v */
// Counter array mode block: cycle configuration, mode registers and six modules
//
// Summary of operation
// [R1] Reload select steers compare byte addresses to reload registers instead of compare.
// [R2] Reload values act only in 9, 10 and 11-bit PWM.
// [R3] Cycle overflow flag requests an interrupt only while its enable is set.
// [R4] Cycle overflow flag sets on counter overflow at bit 8 to 11 by length.
// [R5] Overflow flag set by hardware or software one; only software clears it.
// [R6] Unused configuration bits read zero and ignore writes.
// [R7] Length code 00, 01, 10 gives 8, 9, 10-bit PWM cycles.
// [R8] A 16-bit PWM module ignores the shared length field.
// [R9] Wide PWM bit picks 16-bit PWM, else 8 to 11-bit.
// [R10] Comparator enable turns on the module compare against the counter.
// [R11] Capture counter on rising or falling input edges as enabled.
// [R12] Match enable sets the module event flag on counter equal compare.
// [R13] Toggle enable inverts the module pin on each match.
// [R14] Toggle plus PWM enable selects frequency output mode.
// [R15] PWM enable drives a pulse width modulated pin.
// [R16] Module flag raises interrupt only when its flag interrupt enable is set.
// [R17] While watchdog is on, module 5 mode writes are rejected; it is watchdog.
// [R18] Software turns the watchdog off before changing module 5.
// [R19] Low compare byte write clears the module comparator enable.
// [R20] High compare byte write sets the module comparator enable.
// [R21] Hardware only sets module flags; software clears them.
// [R22] In 9 to 11-bit PWM, reload copies into compare at cycle overflow.
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.vh"
module cam_top (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Main counter and control register
    input wire [15:0] count_value,
    input wire count_tick,
    input wire watchdog_on,
    input wire [5:0] module_event_flag,
    // Events toward the control register
    output reg [5:0] module_event_set,
    output reg watchdog_match,
    output wire counter_array_irq,
    // Module pins
    input wire [5:0] module_io_in,
    output wire [5:0] module_io_out,
    output wire [5:0] module_io_oe
);

// Index of a compare low byte address, or none
function [2:0] lo_index;
    input [7:0] a;
    begin
        case (a)
            `CAM_ADDR_LO0: lo_index = 3'd0;
            `CAM_ADDR_LO1: lo_index = 3'd1;
            `CAM_ADDR_LO2: lo_index = 3'd2;
            `CAM_ADDR_LO3: lo_index = 3'd3;
            `CAM_ADDR_LO4: lo_index = 3'd4;
            `CAM_ADDR_LO5: lo_index = 3'd5;
            default: lo_index = `CAM_NO_MODULE;
        endcase
    end
endfunction

// Index of a compare high byte address, or none
function [2:0] hi_index;
    input [7:0] a;
    begin
        case (a)
            `CAM_ADDR_HI0: hi_index = 3'd0;
            `CAM_ADDR_HI1: hi_index = 3'd1;
            `CAM_ADDR_HI2: hi_index = 3'd2;
            `CAM_ADDR_HI3: hi_index = 3'd3;
            `CAM_ADDR_HI4: hi_index = 3'd4;
            `CAM_ADDR_HI5: hi_index = 3'd5;
            default: hi_index = `CAM_NO_MODULE;
        endcase
    end
endfunction

// Index of a mode register address, or none
function [2:0] mode_index;
    input [7:0] a;
    begin
        case (a)
            `CAM_ADDR_MODE0: mode_index = 3'd0;
            `CAM_ADDR_MODE1: mode_index = 3'd1;
            `CAM_ADDR_MODE2: mode_index = 3'd2;
            `CAM_ADDR_MODE3: mode_index = 3'd3;
            `CAM_ADDR_MODE4: mode_index = 3'd4;
            `CAM_ADDR_MODE5: mode_index = 3'd5;
            default: mode_index = `CAM_NO_MODULE;
        endcase
    end
endfunction

// Cycle configuration fields
reg reload_bank_select_q;
reg cycle_overflow_irq_en_q;
reg cycle_overflow_flag_q;
reg cycle_overflow_flag_d;
reg [1:0] cycle_length_sel_q;

// Per-module storage
reg [7:0] mode_q [0:5];
reg [15:0] reload_q [0:5];
wire [15:0] compare_w [0:5];
wire [5:0] match_w;
wire [5:0] event_w;
wire [5:0] level_w;
reg [5:0] level_prev_q;

wire [2:0] lo_sel = lo_index(sfr_addr);
wire [2:0] hi_sel = hi_index(sfr_addr);
wire [2:0] md_sel = mode_index(sfr_addr);
wire cfg_wr = sfr_wr & (sfr_addr == `CAM_ADDR_PWM_CFG);

// Cycle length and overflow detect
reg [15:0] len_mask;
always @* begin
    case (cycle_length_sel_q)
        `CAM_LEN_8: len_mask = `CAM_MASK_8; // see [R7]
        `CAM_LEN_9: len_mask = `CAM_MASK_9;
        `CAM_LEN_10: len_mask = `CAM_MASK_10;
        `CAM_LEN_11: len_mask = `CAM_MASK_11;
        default: len_mask = `CAM_MASK_8;
    endcase
end

// Freshly ticked counter with all cycle bits zero has just rolled over
wire cycle_ovf = count_tick & ((count_value & len_mask) == `CAM_WORD_ZERO); // see [R4]
wire reload_allowed = (cycle_length_sel_q != `CAM_LEN_8); // see [R2]

// Hardware set wins over a software clear in the same cycle
always @* begin
    cycle_overflow_flag_d = cycle_overflow_flag_q;
    if (cfg_wr) begin
        cycle_overflow_flag_d = sfr_wdata[`CAM_CFG_COV_FLAG]; // see [R5]
    end
    if (cycle_ovf) begin
        cycle_overflow_flag_d = 1'b1; // see [R5]
    end
end

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        reload_bank_select_q <= 1'b0;
        cycle_overflow_irq_en_q <= 1'b0;
        cycle_overflow_flag_q <= 1'b0;
        cycle_length_sel_q <= `CAM_LEN_8;
    end else begin
        cycle_overflow_flag_q <= cycle_overflow_flag_d;
        if (cfg_wr) begin
            // Bits 4:2 are dropped
            reload_bank_select_q <= sfr_wdata[`CAM_CFG_RELOAD_SEL]; // see [R6]
            cycle_overflow_irq_en_q <= sfr_wdata[`CAM_CFG_COV_IRQ];
            cycle_length_sel_q <= sfr_wdata[`CAM_CFG_LEN_HI:`CAM_CFG_LEN_LO];
        end
    end
end

genvar g;
generate
    for (g = 0; g < `CAM_NUM_MODULES; g = g + 1) begin : gen_mod
        wire is_wdt = (g == `CAM_WDT_MODULE);
        // Watchdog locks the module 5 mode register against every write path
        wire locked = is_wdt & watchdog_on; // see [R17] [R18]
        wire hit_lo = sfr_wr & (lo_sel == g);
        wire hit_hi = sfr_wr & (hi_sel == g);
        wire hit_md = sfr_wr & (md_sel == g) & ~locked;

        always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                mode_q[g] <= `CAM_MODE_RESET;
            end else if (hit_md) begin
                mode_q[g] <= sfr_wdata;
            end else if (hit_lo & ~locked) begin
                mode_q[g][`CAM_MODE_CMP_EN] <= 1'b0; // see [R19]
            end else if (hit_hi & ~locked) begin
                mode_q[g][`CAM_MODE_CMP_EN] <= 1'b1; // see [R20]
            end
        end

        always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                reload_q[g] <= `CAM_WORD_ZERO;
            end else if (hit_lo & reload_bank_select_q) begin
                reload_q[g][7:0] <= sfr_wdata; // see [R1]
            end else if (hit_hi & reload_bank_select_q) begin
                reload_q[g][15:8] <= sfr_wdata;
            end
        end

        cam_sync u_sync (
            .mclk(mclk),
            .rstn(rstn),
            .pin_in(module_io_in[g]),
            .level_q(level_w[g])
        );

        cam_channel u_chan (
            .mclk(mclk),
            .rstn(rstn),
            .mode(mode_q[g]),
            .len_mask(len_mask),
            .reload(reload_q[g]),
            .reload_allowed(reload_allowed),
            .count_value(count_value),
            .count_tick(count_tick),
            .cycle_ovf(cycle_ovf),
            .wr_lo(hit_lo & ~reload_bank_select_q), // see [R1]
            .wr_hi(hit_hi & ~reload_bank_select_q),
            .wdata(sfr_wdata),
            .pin_rise(level_w[g] & ~level_prev_q[g]),
            .pin_fall(~level_w[g] & level_prev_q[g]),
            .compare_q(compare_w[g]),
            .match_hit(match_w[g]),
            .event_set(event_w[g]),
            .pin_q(module_io_out[g])
        );

        // Pin is driven in toggle, PWM or frequency output modes
        assign module_io_oe[g] = mode_q[g][`CAM_MODE_TOGGLE] | mode_q[g][`CAM_MODE_PWM];
    end
endgenerate

// Flag sets are registered pulses; the control register keeps the flags
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        level_prev_q <= 6'h0;
        module_event_set <= 6'h0;
        watchdog_match <= 1'b0;
    end else begin
        level_prev_q <= level_w;
        module_event_set <= event_w; // see [R12] [R21]
        watchdog_match <= watchdog_on & match_w[`CAM_WDT_MODULE]; // see [R17]
    end
end

// Combined interrupt request
reg module_irq;
integer i;
always @* begin
    module_irq = 1'b0;
    for (i = 0; i < `CAM_NUM_MODULES; i = i + 1) begin
        module_irq = module_irq | (module_event_flag[i] & mode_q[i][`CAM_MODE_FLAG_IRQ]); // see [R16]
    end
end

assign counter_array_irq = module_irq |
                           (cycle_overflow_flag_q & cycle_overflow_irq_en_q); // see [R3]

// Read data, registered so it settles one edge after the address
reg [7:0] rd_d;
always @* begin
    rd_d = `CAM_BYTE_ZERO;
    if (sfr_addr == `CAM_ADDR_PWM_CFG) begin
        rd_d = {reload_bank_select_q, cycle_overflow_irq_en_q, cycle_overflow_flag_q,
                `CAM_UNUSED_READ, cycle_length_sel_q}; // see [R6]
    end else if (md_sel != `CAM_NO_MODULE) begin
        rd_d = mode_q[md_sel];
    end else if (lo_sel != `CAM_NO_MODULE) begin
        rd_d = reload_bank_select_q ? reload_q[lo_sel][7:0] : compare_w[lo_sel][7:0];
    end else if (hi_sel != `CAM_NO_MODULE) begin
        rd_d = reload_bank_select_q ? reload_q[hi_sel][15:8] : compare_w[hi_sel][15:8];
    end
end

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        sfr_rdata <= `CAM_BYTE_ZERO;
    end else begin
        sfr_rdata <= rd_d;
    end
end

endmodule
`default_nettype wire

/* testbench/cam_properties.sv */
// Port-level checker for the counter array mode block
`timescale 1ns/10ps
`default_nettype none
module cam_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_rdata,
    // Counter side and events
    input wire logic count_tick,
    input wire logic watchdog_on,
    input wire logic [5:0] module_event_flag,
    input wire logic [5:0] module_event_set,
    input wire logic watchdog_match,
    input wire logic counter_array_irq,
    // Pins
    input wire logic [5:0] module_io_out,
    input wire logic [5:0] module_io_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    unused_zero_a: assert property ($past(sfr_addr) == 8'hdf |-> sfr_rdata[4:2] == 3'h0)
        else $error("unused config bits read nonzero");
    cov_irq_a: assert property (($past(sfr_addr) == 8'hdf && !$past(sfr_wr)
        && sfr_rdata[6:5] == 2'h3) |-> counter_array_irq) else $error("overflow irq missing");
    flag_irq_a: assert property (($past(sfr_addr) == 8'hda && !$past(sfr_wr)
        && sfr_rdata[0] && module_event_flag[0]) |-> counter_array_irq)
        else $error("module flag irq missing");
    wdt_lock_a: assert property ((watchdog_on && sfr_addr == 8'hce)[*3]
        |=> sfr_rdata == $past(sfr_rdata, 2)) else $error("guarded mode reg changed");
    hi_sets_a: assert property ((sfr_wr && sfr_addr == 8'hfc) ##1 !sfr_wr
        ##1 (sfr_addr == 8'hda && !sfr_wr) |=> sfr_rdata[6]) else $error("high write no enable");
    lo_clears_a: assert property ((sfr_wr && sfr_addr == 8'hfb) ##1 !sfr_wr
        ##1 (sfr_addr == 8'hda && !sfr_wr) |=> !sfr_rdata[6]) else $error("low write kept enable");
    wdt_tick_a: assert property (watchdog_match |-> $past(count_tick) && $past(watchdog_on))
        else $error("watchdog match without tick");
    cov_sticky_a: assert property (($past(sfr_addr) == 8'hdf && !$past(sfr_wr)
        && sfr_rdata[5] && sfr_addr == 8'hdf) |=> sfr_rdata[5]) else $error("overflow flag lost");
    pin_cause_a: assert property ((!$past(sfr_wr) && !$past(sfr_wr, 2))
        |-> ((module_io_out ^ $past(module_io_out)) & ~$past(module_io_oe)) == 6'h00)
        else $error("undriven pin changed");
    cover property (module_event_set[0]);
    cover property (watchdog_match);
    cover property (sfr_wr && sfr_addr == 8'hdf);
endmodule
bind cam_top cam_properties i_cam_properties (.mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .count_tick(count_tick), .watchdog_on(watchdog_on),
    .module_event_flag(module_event_flag), .module_event_set(module_event_set),
    .watchdog_match(watchdog_match), .counter_array_irq(counter_array_irq),
    .module_io_out(module_io_out), .module_io_oe(module_io_oe));
`default_nettype wire

/* testbench/cam_pin_model.sv */
// Far-side model of the module pins
`timescale 1ns/10ps
`default_nettype none
module cam_pin_model (
    // Level the far side offers
    input wire logic [5:0] drive_lvl,
    // Block side
    input wire logic [5:0] module_io_out,
    input wire logic [5:0] module_io_oe,
    // Resolved pin level
    output wire logic [5:0] module_io_in
);
    // Far side yields where the block drives, so the wire never fights
    assign module_io_in = (module_io_oe & module_io_out) | (~module_io_oe & drive_lvl);
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the counter array mode block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct {string nm; logic [15:0] v;} note_t;
    logic mclk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, count_tick = 1'b0, watchdog_on = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, d;
    logic [15:0] count_value = 16'h0000, obs;
    logic [5:0] module_event_flag = 6'h00, drive_lvl = 6'h00;
    logic [2:0] look = 3'h0;
    logic [7:0] md_a [6] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};
    logic [7:0] lo_a [6] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
    logic [7:0] hi_a [6] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};
    wire [7:0] sfr_rdata;
    wire [5:0] module_event_set, module_io_out, module_io_oe, module_io_in;
    wire watchdog_match, counter_array_irq;
    note_t q[$];
    note_t n;
    int n_fail = 0;
    int comparisons = 0;
    cam_top i_cam_top (.mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .count_value(count_value),
        .count_tick(count_tick), .watchdog_on(watchdog_on),
        .module_event_flag(module_event_flag), .module_event_set(module_event_set),
        .watchdog_match(watchdog_match), .counter_array_irq(counter_array_irq),
        .module_io_in(module_io_in), .module_io_out(module_io_out), .module_io_oe(module_io_oe));
    cam_pin_model i_cam_pin_model (.drive_lvl(drive_lvl), .module_io_out(module_io_out),
        .module_io_oe(module_io_oe), .module_io_in(module_io_in));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Result registered at the edge just passed is judged at the next falling edge
    task automatic expect_at(input logic [2:0] k, input string nm, input logic [15:0] v);
        q.push_back('{nm, v});
        look <= k;
        @(posedge mclk);
        look <= 3'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        @(posedge mclk);
        expect_at(3'h1, "rdata", v);
    endtask
    task automatic tick(input logic [15:0] c);
        @(posedge mclk);
        count_value <= c;
        count_tick <= 1'b1;
        @(posedge mclk);
        count_tick <= 1'b0;
    endtask
    task automatic wait_ev(input int i);
        for (int k = 0; k < 12 && module_event_set[i] !== 1'b1; k++) @(negedge mclk);
        if (module_event_set[i] !== 1'b1) begin
            $display("[ERR] capture event expected 1 seen 0");
            n_fail++;
            wrap_up();
        end
    endtask
    always @(negedge mclk) begin
        if (look != 3'h0) begin
            n = q.pop_front();
            case (look)
                3'h1: obs = {8'h00, sfr_rdata};
                3'h2: obs = {10'h000, module_event_set};
                3'h3: obs = {15'h0000, module_io_out[1]};
                3'h4: obs = {15'h0000, counter_array_irq};
                3'h5: obs = {15'h0000, watchdog_match};
                default: obs = {15'h0000, module_io_out[2]};
            endcase
            comparisons++;
            if (obs !== n.v) begin
                $display("[ERR] %s expected %h seen %h", n.nm, n.v, obs);
                n_fail++;
            end
        end
    end
    initial begin
        d = $urandom(38142);
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(md_a[i], 16'h0000);
        rd(8'hdf, 16'h0000);
        rd(8'h00, 16'h0000);
        wr(8'hdf, 8'hff);
        rd(8'hdf, 16'h00e3);
        wr(8'hdf, 8'h00);
        rd(8'hdf, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            wr(md_a[i], d);
            rd(md_a[i], {8'h00, d});
            wr(lo_a[i], $urandom);
            rd(md_a[i], {8'h00, d & 8'hbf});
            wr(hi_a[i], $urandom);
            rd(md_a[i], {8'h00, d | 8'h40});
            wr(md_a[i], 8'h00);
        end
        // Mid-run reset clears pin and compare state left by the random modes
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd(8'hdb, 16'h0000);
        rd(8'hdf, 16'h0000);
        wr(8'hce, 8'h48);
        wr(8'hd2, 8'h40);
        wr(8'hd3, 8'h00);
        watchdog_on <= 1'b1;
        wr(8'hce, 8'hff);
        rd(8'hce, 16'h0048);
        // Compare bytes still land while locked; keep the match value, check the enable
        wr(8'hd2, 8'h40);
        rd(8'hce, 16'h0048);
        tick(16'h0040);
        expect_at(3'h5, "watchdog match", 16'h0001);
        watchdog_on <= 1'b0;
        wr(8'hce, 8'h00);
        wr(8'hda, 8'h09);
        wr(8'hfb, 8'h10);
        wr(8'hfc, 8'h00);
        tick(16'h0010);
        expect_at(3'h2, "event set", 16'h0001);
        tick(16'h0011);
        expect_at(3'h2, "event set", 16'h0000);
        module_event_flag <= 6'h01;
        rd(8'hda, 16'h0049);
        expect_at(3'h4, "flag irq", 16'h0001);
        wr(8'hda, 8'h48);
        expect_at(3'h4, "flag irq", 16'h0000);
        module_event_flag <= 6'h00;
        wr(8'hdb, 8'h44);
        wr(8'he9, 8'h20);
        wr(8'hea, 8'h00);
        tick(16'h0020);
        expect_at(3'h3, "toggle pin", 16'h0001);
        tick(16'h0021);
        tick(16'h0020);
        expect_at(3'h3, "toggle pin", 16'h0000);
        wr(8'hdc, 8'h42);
        wr(8'heb, 8'h80);
        wr(8'hec, 8'h00);
        tick(16'h0190);
        expect_at(3'h6, "pwm pin", 16'h0001);
        tick(16'h0010);
        expect_at(3'h6, "pwm pin", 16'h0000);
        wr(8'hdc, 8'hc2);
        wr(8'hec, 8'h80);
        tick(16'h0190);
        expect_at(3'h6, "wide pin", 16'h0000);
        tick(16'h8090);
        expect_at(3'h6, "wide pin", 16'h0001);
        wr(8'hdc, 8'h00);
        for (int l = 0; l < 4; l++) begin
            wr(8'hdf, 8'h40 | l[7:0]);
            tick(16'h0001 << (l + 7));
            rd(8'hdf, {8'h00, 8'h40 | l[7:0]});
            tick(16'h0001 << (l + 8));
            rd(8'hdf, {8'h00, 8'h60 | l[7:0]});
            expect_at(3'h4, "cov irq", 16'h0001);
        end
        wr(8'hdf, 8'h23);
        expect_at(3'h4, "cov irq", 16'h0000);
        wr(8'hdf, 8'h80);
        wr(8'hfb, 8'h55);
        rd(8'hfb, 16'h0055);
        wr(8'hdf, 8'h00);
        rd(8'hfb, 16'h0010);
        wr(8'hdd, 8'h20);
        count_value <= 16'h1234;
        drive_lvl <= 6'h08;
        wait_ev(3);
        rd(8'hed, 16'h0034);
        wr(8'hdd, 8'h10);
        count_value <= 16'h5678;
        drive_lvl <= 6'h00;
        wait_ev(3);
        rd(8'hee, 16'h0056);
        wrap_up();
    end
endmodule
`default_nettype wire
